// ### shared/hdfifo_defines.vh
// register map, fields, reset values and sizes of the host data buffer
`ifndef HDFIFO_DEFINES_VH
`define HDFIFO_DEFINES_VH

// sizes
`define HDF_DEPTH 512
`define HDF_AW 9
`define HDF_CW 10
`define HDF_CAP_FULL 10'h200
`define HDF_CAP_SMALL 10'h0ff

// register indices, byte address is four times the index
`define HDF_IDX_CTRL 8'h02
`define HDF_IDX_WMLO 8'h03
`define HDF_IDX_CNT 8'h04
`define HDF_IDX_DATA 8'h05
`define HDF_IDX_IRQ 8'h06
`define HDF_IDX_IEN 8'h07
`define HDF_IDX_ERR 8'h08
`define HDF_IDX_HI 31:10
`define HDF_IDX_LO 9:2
`define HDF_ADDR_HI_ZERO 22'h00_0000

// control register fields
`define HDF_CTL_SIZE 7
`define HDF_CTL_HIAL 6
`define HDF_CTL_LOAL 5
`define HDF_CTL_FLUSH 4
`define HDF_CTL_WMHI 2
`define HDF_CTL_CNTHI 1:0

// interrupt status and enable fields
`define HDF_NEVT 3
`define HDF_IRQ_ERR 0
`define HDF_IRQ_LOAL 1
`define HDF_IRQ_HIAL 2
`define HDF_EVT_BITS 2:0

// error register fields
`define HDF_ERR_OVL 0

// reset values
`define HDF_RST_WMLO 8'h00
`define HDF_RST_WMHI 1'b0
`define HDF_RST_SIZE 1'b0
`define HDF_RST_BYTE 8'h00
`define HDF_RST_WORD 32'h0000_0000
`define HDF_RST_EVT 3'h0

// bus encodings
`define HDF_HRESP_OKAY 1'b0

`endif

// ### hw/hdfifo_mem.v
// byte storage array of the host data buffer
`timescale 1ns/10ps
`default_nettype none

module hdfifo_mem #(
  parameter W = 8,
  parameter D = 512,
  parameter AW = 9
) (
  // clock
  input wire hclk,
  // write side
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  // read side
  input wire [AW-1:0] raddr,
  output wire [W-1:0] rdata
);

  reg [W-1:0] mem [0:D-1];

  always @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];

endmodule // hdfifo_mem

`default_nettype wire

// ### hw/hdfifo_irq.v
// sticky event status, enable mask and interrupt output
`timescale 1ns/10ps
`default_nettype none

module hdfifo_irq #(
  parameter N = 3
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // events, one-cycle pulses
  input wire [N-1:0] evt,
  // software access
  input wire clr_we,
  input wire [N-1:0] clr_bits,
  input wire msk_we,
  input wire [N-1:0] msk_bits,
  // state
  output reg [N-1:0] status_q,
  output reg [N-1:0] mask_q,
  output wire irq
);

  wire [N-1:0] clr;

  assign clr = clr_we ? clr_bits : {N{1'b0}};

  // set wins over a clear in the same cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= {N{1'b0}};
      mask_q <= {N{1'b0}};
    end else begin
      status_q <= (status_q & ~clr) | evt;
      if (msk_we) begin
        mask_q <= msk_bits;
      end
    end
  end

  assign irq = |(status_q & mask_q);

endmodule // hdfifo_irq

`default_nettype wire

// ### hw/hdfifo_top.v
// host data buffer: byte fifo shared by the host bus and the command engine
//
// Summary of operation
// [R1] one byte-wide 512-entry buffer carries data between host and command engine.
// [R2] with the size limit set the capacity is 255 bytes and level and watermark use one byte.
// [R3] at full capacity level and watermark are wider than a byte and span two registers.
// [R4] the command engine may push or pop the buffer at any time its command needs; pushes stall on bus data writes, pops on bus data reads, both on flushes.
// [R5] the host must not touch the buffer in a way that corrupts data a running command uses.
// [R6] writing one to the flush bit resets both pointers and clears the level to zero.
// [R7] each stored byte raises the level and each read byte lowers it; the host reads it back.
// [R8] the watermark is control bit 2 as its upper part and register 03h as its low byte.
// [R9] a write into a full buffer sets the overflow flag, reported as the error event flag.
// [R10] one watermark serves as distance from the top for almost-full and from the bottom.
// [R11] almost-full is one while capacity minus level is at most the watermark.
// [R12] almost-empty is one while the level is at most the watermark.
// [R13] with its enable set, a rise of almost-empty raises the interrupt output.
// [R14] with its enable set, a rise of almost-full raises the interrupt output.
// [R15] a write into a full buffer is dropped and a read of an empty one leaves level zero.
// [R16] after reset the buffer is empty, almost-empty set, almost-full and overflow clear.
`timescale 1ns/10ps
`default_nettype none
`include "hdfifo_defines.vh"

module hdfifo_top #(
  parameter AW = `HDF_AW,
  parameter CW = `HDF_CW,
  parameter DEPTH = `HDF_DEPTH,
  parameter [CW-1:0] CAP_FULL = `HDF_CAP_FULL,
  parameter [CW-1:0] CAP_SMALL = `HDF_CAP_SMALL
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // command engine push side
  input wire sm_push,
  input wire [7:0] sm_push_data,
  output wire sm_push_ready,
  // command engine pop side
  input wire sm_pop,
  output wire sm_pop_ready,
  output reg [7:0] sm_pop_data_q,
  output reg sm_pop_valid_q,
  // status
  output wire almost_full_flag,
  output wire almost_empty_flag,
  output wire irq
);

  localparam [1:0] BUS_IDLE = 2'h0;
  localparam [1:0] BUS_WAIT = 2'h1;
  localparam [1:0] BUS_DONE = 2'h2;

  // bus phase tracking
  reg [1:0] bus_state_q;
  reg [1:0] bus_state_d;
  reg [7:0] idx_q;
  reg hit_q;
  reg wr_q;
  wire accept;
  wire in_wait;
  wire wr_now;
  wire rd_now;

  // buffer state
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [CW-1:0] stored_byte_count_q;
  reg [CW-1:0] count_d;

  // configuration
  reg size_limit_select_q;
  reg wm_hi_q;
  reg [7:0] fifo_watermark_low_q;
  reg overflow_flag_q;
  reg prev_lo_q;
  reg prev_hi_q;

  // datapath
  wire [CW-1:0] cap;
  wire [CW-1:0] watermark_value;
  wire [CW-1:0] free_space;
  wire full;
  wire empty;
  wire buffer_flush;
  wire bus_push;
  wire bus_pop;
  wire push_req;
  wire [7:0] push_data;
  wire do_push;
  wire do_pop;
  wire sm_pop_take;
  wire ovl_evt;
  wire [7:0] mem_rdata;
  wire [`HDF_NEVT-1:0] evt;
  wire [`HDF_NEVT-1:0] interrupt_flags_0;
  wire [`HDF_NEVT-1:0] interrupt_enables_0;
  wire irq_clr_we;
  wire ien_we;
  wire [7:0] buffer_control_reg;
  reg [7:0] rd_byte;

  // ahb address phase and wait state
  assign accept = hsel & htrans[1] & hready & (bus_state_q != BUS_WAIT);
  assign in_wait = (bus_state_q == BUS_WAIT);
  assign wr_now = in_wait & wr_q & hit_q;
  assign rd_now = in_wait & ~wr_q & hit_q;
  assign hreadyout = ~in_wait;
  assign hresp = `HDF_HRESP_OKAY;

  always @* begin
    case (bus_state_q)
      BUS_WAIT: begin
        bus_state_d = BUS_DONE;
      end
      BUS_IDLE, BUS_DONE: begin
        if (accept) begin
          bus_state_d = BUS_WAIT;
        end else begin
          bus_state_d = BUS_IDLE;
        end
      end
      default: begin
        bus_state_d = BUS_IDLE;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_q <= BUS_IDLE;
      idx_q <= `HDF_RST_BYTE;
      hit_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      bus_state_q <= bus_state_d;
      if (accept) begin
        idx_q <= haddr[`HDF_IDX_LO];
        hit_q <= (haddr[`HDF_IDX_HI] == `HDF_ADDR_HI_ZERO);
        wr_q <= hwrite;
      end
    end
  end

  // capacity and watermark
  assign cap = size_limit_select_q ? CAP_SMALL : CAP_FULL; // see [R2]
  assign watermark_value = size_limit_select_q ?
    {{(CW-8){1'b0}}, fifo_watermark_low_q} : // see [R2]
    {{(CW-9){1'b0}}, wm_hi_q, fifo_watermark_low_q}; // see [R8] see [R3]
  assign full = (stored_byte_count_q >= cap);
  assign empty = (stored_byte_count_q == {CW{1'b0}});
  assign free_space = full ? {CW{1'b0}} : (cap - stored_byte_count_q);

  // flags from the one watermark
  assign almost_full_flag = (free_space <= watermark_value); // see [R10] see [R11]
  assign almost_empty_flag = (stored_byte_count_q <= watermark_value); // see [R10] see [R12]

  // data port access from the bus
  assign buffer_flush = wr_now & (idx_q == `HDF_IDX_CTRL) & hwdata[`HDF_CTL_FLUSH]; // see [R6]
  assign bus_push = wr_now & (idx_q == `HDF_IDX_DATA);
  assign bus_pop = rd_now & (idx_q == `HDF_IDX_DATA);

  // bus has priority, engine stalls for that cycle
  assign push_req = bus_push | sm_push; // see [R4]
  assign push_data = bus_push ? hwdata[7:0] : sm_push_data;
  assign sm_push_ready = ~bus_push & ~buffer_flush; // see [R4]
  assign sm_pop_ready = ~bus_pop & ~empty & ~buffer_flush; // see [R4]
  assign sm_pop_take = sm_pop & sm_pop_ready;

  // dropped when full, ignored when empty
  assign do_push = push_req & ~full & ~buffer_flush; // see [R15]
  assign ovl_evt = push_req & full & ~buffer_flush; // see [R9]
  assign do_pop = (bus_pop | sm_pop_take) & ~empty & ~buffer_flush; // see [R15]

  // level counter
  always @* begin
    if (buffer_flush) begin
      count_d = {CW{1'b0}}; // see [R6]
    end else begin
      count_d = stored_byte_count_q
        + {{(CW-1){1'b0}}, do_push}
        - {{(CW-1){1'b0}}, do_pop}; // see [R7]
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_q <= {AW{1'b0}}; // see [R16]
      rd_ptr_q <= {AW{1'b0}};
      stored_byte_count_q <= {CW{1'b0}};
    end else begin
      stored_byte_count_q <= count_d;
      if (buffer_flush) begin
        wr_ptr_q <= {AW{1'b0}}; // see [R6]
        rd_ptr_q <= {AW{1'b0}};
      end else begin
        if (do_push) begin
          wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
        if (do_pop) begin
          rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // single storage array for both directions
  hdfifo_mem #(
    .W(8),
    .D(DEPTH),
    .AW(AW)
  ) u_mem (
    .hclk(hclk),
    .we(do_push), // see [R1]
    .waddr(wr_ptr_q),
    .wdata(push_data),
    .raddr(rd_ptr_q),
    .rdata(mem_rdata)
  );

  // engine pop data
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sm_pop_data_q <= `HDF_RST_BYTE;
      sm_pop_valid_q <= 1'b0;
    end else begin
      sm_pop_valid_q <= sm_pop_take;
      if (sm_pop_take) begin
        sm_pop_data_q <= mem_rdata; // see [R4]
      end
    end
  end

  // configuration registers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      size_limit_select_q <= `HDF_RST_SIZE;
      wm_hi_q <= `HDF_RST_WMHI;
      fifo_watermark_low_q <= `HDF_RST_WMLO;
    end else begin
      if (wr_now & (idx_q == `HDF_IDX_CTRL)) begin
        size_limit_select_q <= hwdata[`HDF_CTL_SIZE]; // see [R2]
        wm_hi_q <= hwdata[`HDF_CTL_WMHI]; // see [R8]
      end
      if (wr_now & (idx_q == `HDF_IDX_WMLO)) begin
        fifo_watermark_low_q <= hwdata[7:0]; // see [R8]
      end
    end
  end

  // overflow flag, set wins over clear, a flush in the same cycle wins over set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overflow_flag_q <= 1'b0; // see [R16]
    end else begin
      if (ovl_evt) begin
        overflow_flag_q <= 1'b1; // see [R9]
      end else if (buffer_flush) begin
        overflow_flag_q <= 1'b0;
      end else if (wr_now & (idx_q == `HDF_IDX_ERR) & hwdata[`HDF_ERR_OVL]) begin
        overflow_flag_q <= 1'b0;
      end
    end
  end

  // previous flag values for rise detection
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_lo_q <= 1'b1; // see [R16]
      prev_hi_q <= 1'b0;
    end else begin
      prev_lo_q <= almost_empty_flag;
      prev_hi_q <= almost_full_flag;
    end
  end

  assign evt[`HDF_IRQ_ERR] = ovl_evt; // see [R9]
  assign evt[`HDF_IRQ_LOAL] = almost_empty_flag & ~prev_lo_q; // see [R13]
  assign evt[`HDF_IRQ_HIAL] = almost_full_flag & ~prev_hi_q; // see [R14]

  assign irq_clr_we = wr_now & (idx_q == `HDF_IDX_IRQ);
  assign ien_we = wr_now & (idx_q == `HDF_IDX_IEN);

  // interrupt status and enables
  hdfifo_irq #(
    .N(`HDF_NEVT)
  ) u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .evt(evt),
    .clr_we(irq_clr_we),
    .clr_bits(hwdata[`HDF_EVT_BITS]),
    .msk_we(ien_we),
    .msk_bits(hwdata[`HDF_EVT_BITS]),
    .status_q(interrupt_flags_0),
    .mask_q(interrupt_enables_0),
    .irq(irq) // see [R13] see [R14]
  );

  // control register view
  assign buffer_control_reg = {
    size_limit_select_q,
    almost_full_flag,
    almost_empty_flag,
    1'b0,
    1'b0,
    wm_hi_q,
    stored_byte_count_q[CW-1:8] // see [R3] see [R7]
  };

  // read data select
  always @* begin
    case (idx_q)
      `HDF_IDX_CTRL: begin
        rd_byte = buffer_control_reg;
      end
      `HDF_IDX_WMLO: begin
        rd_byte = fifo_watermark_low_q;
      end
      `HDF_IDX_CNT: begin
        rd_byte = stored_byte_count_q[7:0]; // see [R7]
      end
      `HDF_IDX_DATA: begin
        rd_byte = empty ? `HDF_RST_BYTE : mem_rdata; // see [R15]
      end
      `HDF_IDX_IRQ: begin
        rd_byte = {5'h00, interrupt_flags_0};
      end
      `HDF_IDX_IEN: begin
        rd_byte = {5'h00, interrupt_enables_0};
      end
      `HDF_IDX_ERR: begin
        rd_byte = {7'h00, overflow_flag_q};
      end
      default: begin
        rd_byte = `HDF_RST_BYTE;
      end
    endcase
  end

  // read data held through the answer cycle
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= `HDF_RST_WORD;
    end else begin
      if (rd_now) begin
        hrdata <= {24'h00_0000, rd_byte};
      end else if (in_wait) begin
        hrdata <= `HDF_RST_WORD;
      end
    end
  end

endmodule // hdfifo_top

`default_nettype wire

// ### verification/hdf_top_sva.sv
// port assertions of the host data buffer
`timescale 1ns/10ps
`default_nettype none
module hdf_top_sva (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // engine
  input wire sm_push,
  input wire sm_push_ready,
  input wire sm_pop,
  input wire sm_pop_ready,
  input wire sm_pop_valid_q,
  // status
  input wire almost_full_flag,
  input wire almost_empty_flag,
  input wire irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence pop_taken;
    sm_pop && sm_pop_ready;
  endsequence
  a_wait_state: assert property (hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("bus wait state not exactly one cycle");
  a_hrdata_hold: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved outside a transfer");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_hrdata_byte: assert property (hrdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  a_pop_answer: assert property (pop_taken |=> sm_pop_valid_q)
    else $error("taken pop gave no valid byte");
  a_valid_cause: assert property (sm_pop_valid_q |-> $past(sm_pop && sm_pop_ready))
    else $error("valid byte without a taken pop");
  a_push_stall: assert property (!sm_push_ready |-> !hreadyout)
    else $error("push refused outside a bus transfer");
  a_reset_state: assert property ($rose(hresetn) |-> almost_empty_flag && !almost_full_flag && !irq)
    else $error("flags wrong after reset");
  c_pop_b2b: cover property (pop_taken ##1 pop_taken);
  c_irq_rise: cover property ($rose(irq));
  c_full_rise: cover property ($rose(almost_full_flag) && sm_push);
endmodule // hdf_top_sva
`default_nettype wire

// ### verification/hdf_engine.sv
// command engine model pushing and popping the buffer
`timescale 1ns/10ps
`default_nettype none
module hdf_engine (
  // clock
  input wire logic hclk,
  // push side
  output logic sm_push,
  output logic [7:0] sm_push_data,
  input wire logic sm_push_ready,
  // pop side
  output logic sm_pop,
  input wire logic sm_pop_ready,
  input wire logic [7:0] sm_pop_data_q,
  input wire logic sm_pop_valid_q
);
  logic [7:0] got[$];
  int hang = 0;
  initial begin
    sm_push = 1'b0;
    sm_push_data = 8'h00;
    sm_pop = 1'b0;
  end
  // n bytes back to back, base plus index
  task automatic push_burst(input int n, input logic [7:0] base);
    int k;
    int t;
    k = 0;
    t = 0;
    sm_push <= 1'b1;
    sm_push_data <= base;
    while (k < n && t < 4 * n + 20) begin
      @(posedge hclk);
      t++;
      if (sm_push_ready === 1'b1) begin
        k++;
        if (k < n) sm_push_data <= 8'(base + k);
        else begin
          sm_push <= 1'b0;
          sm_push_data <= ~sm_push_data;
        end
      end
    end
    if (k < n) begin
      hang++;
      sm_push <= 1'b0;
    end
  endtask
  task automatic pop_burst(input int n);
    int k;
    int t;
    k = 0;
    t = 0;
    sm_pop <= 1'b1;
    while (k < n && t < 4 * n + 20) begin
      @(posedge hclk);
      t++;
      if (sm_pop_ready === 1'b1) k++;
      if (k == n) sm_pop <= 1'b0;
    end
    if (k < n) begin
      hang++;
      sm_pop <= 1'b0;
    end
    repeat (2) @(posedge hclk);
  endtask
  always @(posedge hclk) begin
    if (sm_pop_valid_q === 1'b1) got.push_back(sm_pop_data_q);
  end
endmodule // hdf_engine
`default_nettype wire

// ### verification/testbench.sv
// self-checking bench of the host data buffer
`timescale 1ns/10ps
`default_nettype none
`include "hdfifo_defines.vh"
module testbench;
  logic hclk = 1'b0;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire sm_push;
  wire [7:0] sm_push_data;
  wire sm_push_ready;
  wire sm_pop;
  wire sm_pop_ready;
  wire [7:0] sm_pop_data_q;
  wire sm_pop_valid_q;
  wire almost_full_flag;
  wire almost_empty_flag;
  wire irq;
  int num_errors = 0;
  int total_checks = 0;
  int q[$];
  int wmlo = 0;
  int wmhi = 0;
  int sz = 0;
  hdfifo_top i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sm_push(sm_push),
    .sm_push_data(sm_push_data), .sm_push_ready(sm_push_ready), .sm_pop(sm_pop),
    .sm_pop_ready(sm_pop_ready), .sm_pop_data_q(sm_pop_data_q),
    .sm_pop_valid_q(sm_pop_valid_q), .almost_full_flag(almost_full_flag),
    .almost_empty_flag(almost_empty_flag), .irq(irq));
  hdf_engine i_eng (
    .hclk(hclk), .sm_push(sm_push), .sm_push_data(sm_push_data),
    .sm_push_ready(sm_push_ready), .sm_pop(sm_pop), .sm_pop_ready(sm_pop_ready),
    .sm_pop_data_q(sm_pop_data_q), .sm_pop_valid_q(sm_pop_valid_q));
  always #25 hclk = ~hclk;
  task stop_test();
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic int wm();
    return sz ? wmlo : wmhi * 256 + wmlo;
  endfunction
  function automatic int cap();
    return sz ? 255 : 512;
  endfunction
  function automatic logic [7:0] exp_ctrl();
    int lv;
    lv = q.size();
    return {sz[0], (cap() - lv <= wm()), (lv <= wm()), 2'b00, wmhi[0], 2'(lv / 256)};
  endfunction
  task automatic bus(input logic wr_n, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int t;
    t = 0;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr_n;
    haddr <= {22'h00_0000, idx, 2'b00};
    do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 50);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin @(posedge hclk); t++; end while (hreadyout !== 1'b1 && t < 50);
    rd = hrdata;
    if (t >= 50) begin
      num_errors++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] r;
    bus(1'b1, idx, wd, r);
  endtask
  task automatic rdc(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0000_0000, r);
    chk(nm, r, exp);
  endtask
  task automatic chk_state();
    logic [7:0] c;
    c = exp_ctrl();
    rdc("ctrl", `HDF_IDX_CTRL, c);
    rdc("count", `HDF_IDX_CNT, q.size() % 256);
    chk("almost_full", almost_full_flag, c[6]);
    chk("almost_empty", almost_empty_flag, c[5]);
  endtask
  task automatic irqc(input logic [2:0] st, input logic pin);
    rdc("irq_status", `HDF_IDX_IRQ, st);
    chk("irq_pin", irq, pin);
  endtask
  task automatic bus_push(input int n);
    logic [7:0] b;
    repeat (n) begin
      b = 8'($urandom);
      wr(`HDF_IDX_DATA, {24'h00_0000, b});
      if (q.size() < cap()) q.push_back(b);
    end
  endtask
  task automatic bus_pop(input int n);
    int e;
    repeat (n) begin
      e = (q.size() > 0) ? q.pop_front() : 0;
      rdc("data", `HDF_IDX_DATA, e);
    end
  endtask
  task automatic eng_push(input int n);
    logic [7:0] b;
    b = 8'($urandom);
    i_eng.push_burst(n, b);
    for (int k = 0; k < n; k++) if (q.size() < cap()) q.push_back(8'(b + k));
  endtask
  task automatic eng_pop(input int n);
    i_eng.got.delete();
    i_eng.pop_burst(n);
    chk("pops", i_eng.got.size(), n);
    foreach (i_eng.got[k]) chk("pop_data", i_eng.got[k], q.pop_front());
  endtask
  initial begin
    #2000000;
    num_errors++;
    stop_test();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    void'($urandom(32'h59ac));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk_state();
    rdc("irq_rst", `HDF_IDX_IRQ, 0);
    rdc("ien_rst", `HDF_IDX_IEN, 0);
    rdc("err_rst", `HDF_IDX_ERR, 0);
    rdc("unmapped", 8'h3c, 0);
    wr(`HDF_IDX_WMLO, 32'h0000_0004);
    wr(`HDF_IDX_CTRL, 32'h0000_0004);
    wmlo = 4;
    wmhi = 1;
    rdc("wmlo", `HDF_IDX_WMLO, 4);
    bus_push(5);
    chk_state();
    eng_push(507);
    chk_state();
    bus_push(1);
    chk_state();
    rdc("overflow", `HDF_IDX_ERR, 1);
    irqc(5, 0);
    wr(`HDF_IDX_IRQ, 32'h0000_0007);
    irqc(0, 0);
    // host stays off the data port during engine pops
    eng_pop(300);
    chk_state();
    irqc(2, 0);
    wr(`HDF_IDX_IEN, 32'h0000_0002);
    irqc(2, 1);
    wr(`HDF_IDX_IRQ, 32'h0000_0002);
    irqc(0, 0);
    wr(`HDF_IDX_IEN, 32'h0000_0004);
    bus_push(45);
    irqc(4, 1);
    wr(`HDF_IDX_IRQ, 32'h0000_0007);
    wr(`HDF_IDX_CTRL, 32'h0000_0014);
    q.delete();
    chk_state();
    rdc("ovl_flush", `HDF_IDX_ERR, 0);
    bus_pop(1);
    chk_state();
    wr(`HDF_IDX_CTRL, 32'h0000_0080);
    wr(`HDF_IDX_WMLO, 32'h0000_0010);
    sz = 1;
    wmhi = 0;
    wmlo = 16;
    eng_push(256);
    chk_state();
    rdc("ovl_small", `HDF_IDX_ERR, 1);
    bus_pop(3);
    chk_state();
    chk("engine_hang", i_eng.hang, 0);
    stop_test();
  end
endmodule // testbench
bind hdfifo_top hdf_top_sva i_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sm_push(sm_push),
  .sm_push_ready(sm_push_ready), .sm_pop(sm_pop), .sm_pop_ready(sm_pop_ready),
  .sm_pop_valid_q(sm_pop_valid_q), .almost_full_flag(almost_full_flag),
  .almost_empty_flag(almost_empty_flag), .irq(irq));
`default_nettype wire
